// ---- core/modulator_agc_config.sv ----
// Modulator residual, gain limit, flicker shift and AGC timing logic.
// Assumes an APB master on pclk and synchronous modulator-side inputs.
//
// Implementation choice: the APB register port.
module modulator_agc_config
  import modulator_agc_config_pkg::*;
#(
  parameter int unsigned NCH = 2,
  parameter int unsigned FLICKER_W = 24,
  parameter int unsigned SAMPLE_TIME_W = 8
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Sample timing.
  input wire logic [15:0] sample_cycles,
  output logic [15:0] sample_cycles_eff,
  output logic full_start_per_sample,
  // Residual bit limiting.
  input wire logic [2:0] residual_raw,
  output logic [2:0] residual_limited,
  // Channel gains.
  input wire logic [NCH-1:0][3:0] gain_req,
  output logic [NCH-1:0][3:0] gain_applied,
  // AGC sequencing.
  input wire logic agc_predict_req,
  input wire logic [SAMPLE_TIME_W-1:0] sample_time,
  output logic agc_busy,
  output logic agc_predict_start,
  output logic agc_done,
  // Flicker data.
  input wire logic flicker_in_valid,
  input wire logic [FLICKER_W-1:0] flicker_in,
  output logic flicker_out_valid,
  output logic [FLICKER_W-1:0] flicker_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Register storage.
  logic full_start_reg;
  logic [1:0] floor_reg;
  logic [1:0] ceil_reg;
  logic [7:0] rsvd_reg;
  logic [3:0] max_gain_reg;
  logic [3:0] reduction_reg;
  logic [1:0] drop_reg;
  logic [7:0] count_lo_reg;
  logic [2:0] count_hi_reg;
  logic [31:0] rdata_reg;
  logic err_reg;
  logic setup;
  logic wr_en;
  logic hit;
  logic [31:0] rdata_next;

  // Zero wait states: every access phase completes at once.
  assign setup = psel & ~penable;
  assign pready = psel & penable;
  assign wr_en = psel & penable & pwrite;
  assign prdata = rdata_reg;
  assign pslverr = pready & err_reg;

  always_comb begin
    hit = 1'b1;
    rdata_next = 32'h0000_0000;
    if (paddr == ADDR_RESIDUAL_CFG) begin
      rdata_next[FULL_START_BIT] = full_start_reg;
      rdata_next[FLOOR_LSB +: 2] = floor_reg;
      rdata_next[CEIL_LSB +: 2] = ceil_reg;
    end else if (paddr == ADDR_RSVD_CFG) begin
      rdata_next[7:0] = rsvd_reg;
    end else if (paddr == ADDR_GAIN_LIMITS) begin
      rdata_next[MAX_GAIN_LSB +: 4] = max_gain_reg;
      rdata_next[REDUCTION_LSB +: 4] = reduction_reg;
    end else if (paddr == ADDR_FLICKER_SHIFT) begin
      rdata_next[DROP_LSB +: 2] = drop_reg;
    end else if (paddr == ADDR_AGC_COUNT_LO) begin
      rdata_next[7:0] = count_lo_reg;
    end else if (paddr == ADDR_AGC_COUNT_HI) begin
      rdata_next[COUNT_HI_LSB +: 3] = count_hi_reg;
    end else begin
      hit = 1'b0;
    end
  end

  // Read data and error are captured in the setup cycle for the access phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_reg <= 32'h0000_0000;
      err_reg <= 1'b0;
    end else if (setup) begin
      rdata_reg <= pwrite ? 32'h0000_0000 : rdata_next;
      err_reg <= ~hit;
    end
  end

  // Residual configuration register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      full_start_reg <= RESIDUAL_CFG_RST[FULL_START_BIT];
      floor_reg <= RESIDUAL_CFG_RST[FLOOR_LSB +: 2];
      ceil_reg <= RESIDUAL_CFG_RST[CEIL_LSB +: 2];
    end else if (wr_en && paddr == ADDR_RESIDUAL_CFG) begin
      full_start_reg <= pwdata[FULL_START_BIT];
      floor_reg <= pwdata[FLOOR_LSB +: 2];
      ceil_reg <= pwdata[CEIL_LSB +: 2];
    end
  end

  // Reserved byte, kept as plain storage.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rsvd_reg <= RSVD_CFG_RST;
    end else if (wr_en && paddr == ADDR_RSVD_CFG) begin
      rsvd_reg <= pwdata[7:0];
    end
  end

  // Gain limit register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      max_gain_reg <= GAIN_LIMITS_RST[MAX_GAIN_LSB +: 4];
      reduction_reg <= GAIN_LIMITS_RST[REDUCTION_LSB +: 4];
    end else if (wr_en && paddr == ADDR_GAIN_LIMITS) begin
      max_gain_reg <= pwdata[MAX_GAIN_LSB +: 4];
      reduction_reg <= pwdata[REDUCTION_LSB +: 4];
    end
  end

  // Flicker shift register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drop_reg <= FLICKER_SHIFT_RST[DROP_LSB +: 2];
    end else if (wr_en && paddr == ADDR_FLICKER_SHIFT) begin
      drop_reg <= pwdata[DROP_LSB +: 2];
    end
  end

  // AGC sample count, split over two addresses.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_lo_reg <= AGC_COUNT_LO_RST;
      count_hi_reg <= AGC_COUNT_HI_RST;
    end else if (wr_en && paddr == ADDR_AGC_COUNT_LO) begin
      count_lo_reg <= pwdata[7:0];
    end else if (wr_en && paddr == ADDR_AGC_COUNT_HI) begin
      count_hi_reg <= pwdata[COUNT_HI_LSB +: 3];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sample length with optional full start per sample.
  assign full_start_per_sample = full_start_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample_cycles_eff <= 16'h0000;
    end else if (!full_start_reg) begin
      sample_cycles_eff <= sample_cycles;
    end else if (sample_cycles > FULL_START_SAVING) begin
      sample_cycles_eff <= sample_cycles - FULL_START_SAVING;
    end else begin
      sample_cycles_eff <= 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Residual bit limiting; the ceiling is applied last.
  logic [2:0] floor_bits;
  logic [2:0] ceil_bits;
  logic [2:0] floored;

  assign floor_bits = {1'b0, floor_reg};
  assign ceil_bits = 3'({1'b0, ceil_reg} + 3'h1);
  assign floored = (residual_raw < floor_bits) ? floor_bits : residual_raw;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      residual_limited <= 3'h0;
    end else begin
      residual_limited <= (floored > ceil_bits) ? ceil_bits : floored;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AGC sequencer: reduce gains, then time the prediction measurement.
  agc_state_t state_reg;
  agc_state_t state_next;
  logic [9:0] unit_cnt_reg;
  logic [SAMPLE_TIME_W-1:0] step_cnt_reg;
  logic [10:0] samp_cnt_reg;
  logic [10:0] agc_count;
  logic unit_last;
  logic step_last;
  logic samp_last;

  assign agc_count = {count_hi_reg, count_lo_reg};
  assign unit_last = unit_cnt_reg == AGC_UNIT_CYCLES - 10'h001;
  assign step_last = step_cnt_reg == sample_time;
  assign samp_last = samp_cnt_reg == agc_count;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      AGC_IDLE: begin
        if (agc_predict_req) begin
          state_next = AGC_REDUCE;
        end
      end
      AGC_REDUCE: begin
        state_next = AGC_MEASURE;
      end
      AGC_MEASURE: begin
        if (unit_last && step_last && samp_last) begin
          state_next = AGC_DONE;
        end
      end
      default: begin
        state_next = AGC_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= AGC_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Nested counters: unit cycles, then sample time steps, then samples.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unit_cnt_reg <= 10'h000;
      step_cnt_reg <= '0;
      samp_cnt_reg <= 11'h000;
    end else if (state_reg != AGC_MEASURE) begin
      unit_cnt_reg <= 10'h000;
      step_cnt_reg <= '0;
      samp_cnt_reg <= 11'h000;
    end else if (!unit_last) begin
      unit_cnt_reg <= unit_cnt_reg + 10'h001;
    end else begin
      unit_cnt_reg <= 10'h000;
      if (!step_last) begin
        step_cnt_reg <= step_cnt_reg + SAMPLE_TIME_W'(1);
      end else begin
        step_cnt_reg <= '0;
        samp_cnt_reg <= samp_cnt_reg + 11'h001;
      end
    end
  end

  // Status outputs decode the state register directly.
  assign agc_busy = state_reg != AGC_IDLE;
  assign agc_predict_start = state_reg == AGC_REDUCE;
  assign agc_done = state_reg == AGC_DONE;

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel gain limit and AGC reduction.
  // Gains stay reduced until idle, but never exceed a lowered maximum.
  for (genvar ch = 0; ch < NCH; ch++) begin : g_gain
    logic [3:0] capped;
    assign capped = (gain_req[ch] > max_gain_reg) ? max_gain_reg : gain_req[ch];
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        gain_applied[ch] <= 4'h0;
      end else if (state_reg == AGC_IDLE) begin
        gain_applied[ch] <= capped;
      end else if (state_reg == AGC_REDUCE) begin
        gain_applied[ch] <= (capped > reduction_reg) ? capped - reduction_reg : 4'h0;
      end else if (gain_applied[ch] > max_gain_reg) begin
        gain_applied[ch] <= max_gain_reg;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flicker residual drop and shift.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flicker_out <= '0;
      flicker_out_valid <= 1'b0;
    end else begin
      flicker_out_valid <= flicker_in_valid;
      if (flicker_in_valid) begin
        flicker_out <= flicker_in >> drop_reg;
      end
    end
  end

endmodule

// ---- shared/modulator_agc_config_pkg.sv ----
// Constants for the modulator and AGC configuration block.
// Assumes a 250 MHz pclk and a 32-bit APB register bus.
//
// Overview of operation
// - Full start per sample trims nine cycles.
// - Residual count held at or above floor, or at ceiling if that is lower.
// - Residual count held at or below ceiling.
// - Sequencer gain never exceeds programmed maximum.
// - AGC predict first lowers all channel gains.
// - Flicker data drops and shifts residual bits.
// - AGC time is (count+1)(sample+1) units.
// - Eleven-bit AGC count split over two registers.
package modulator_agc_config_pkg;

  ////////////////////////////////////////////////////////////////////////////
  localparam int unsigned ADDR_W = 12;
  localparam logic [7:0] IDX_RESIDUAL_CFG = 8'ha7;
  localparam logic [7:0] IDX_RSVD_CFG = 8'ha8;
  localparam logic [7:0] IDX_GAIN_LIMITS = 8'ha9;
  localparam logic [7:0] IDX_FLICKER_SHIFT = 8'haa;
  localparam logic [7:0] IDX_AGC_COUNT_LO = 8'hac;
  localparam logic [7:0] IDX_AGC_COUNT_HI = 8'had;
  localparam logic [ADDR_W-1:0] ADDR_RESIDUAL_CFG = {2'b00, IDX_RESIDUAL_CFG, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_RSVD_CFG = {2'b00, IDX_RSVD_CFG, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_GAIN_LIMITS = {2'b00, IDX_GAIN_LIMITS, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_FLICKER_SHIFT = {2'b00, IDX_FLICKER_SHIFT, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_AGC_COUNT_LO = {2'b00, IDX_AGC_COUNT_LO, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_AGC_COUNT_HI = {2'b00, IDX_AGC_COUNT_HI, 2'b00};

  ////////////////////////////////////////////////////////////////////////////
  localparam int unsigned FULL_START_BIT = 5;
  localparam int unsigned FLOOR_LSB = 2;
  localparam int unsigned CEIL_LSB = 0;
  localparam int unsigned MAX_GAIN_LSB = 4;
  localparam int unsigned REDUCTION_LSB = 0;
  localparam int unsigned DROP_LSB = 0;
  localparam int unsigned COUNT_HI_LSB = 0;

  ////////////////////////////////////////////////////////////////////////////
  localparam logic [7:0] RESIDUAL_CFG_RST = 8'h03;
  localparam logic [7:0] RSVD_CFG_RST = 8'h01;
  localparam logic [7:0] GAIN_LIMITS_RST = 8'hc4;
  localparam logic [7:0] FLICKER_SHIFT_RST = 8'h00;
  localparam logic [7:0] AGC_COUNT_LO_RST = 8'h00;
  localparam logic [2:0] AGC_COUNT_HI_RST = 3'h0;

  ////////////////////////////////////////////////////////////////////////////
  localparam logic [15:0] FULL_START_SAVING = 16'h0009;
  localparam longint unsigned AGC_UNIT_PS = 1388889;
  localparam longint unsigned CLK_PERIOD_PS = 4000;
  localparam logic [9:0] AGC_UNIT_CYCLES = 10'(AGC_UNIT_PS / CLK_PERIOD_PS);

  typedef enum logic [1:0] {
    AGC_IDLE = 2'b00,
    AGC_REDUCE = 2'b01,
    AGC_MEASURE = 2'b11,
    AGC_DONE = 2'b10
  } agc_state_t;

endpackage

// ---- verif/modulator_agc_config_sva.sv ----
// Checker for the modulator and AGC configuration block.
// Sees only the block's ports; bound to it at the foot.
module modulator_agc_config_sva
  import modulator_agc_config_pkg::*;
#(
  parameter int unsigned NCH = 2,
  parameter int unsigned FLICKER_W = 24,
  parameter int unsigned SAMPLE_TIME_W = 8
) (
  // Bus.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  // Data paths.
  input wire logic [15:0] sample_cycles,
  input wire logic [15:0] sample_cycles_eff,
  input wire logic full_start_per_sample,
  input wire logic [2:0] residual_limited,
  input wire logic [NCH-1:0][3:0] gain_applied,
  input wire logic flicker_in_valid,
  input wire logic [FLICKER_W-1:0] flicker_in,
  input wire logic flicker_out_valid,
  input wire logic [FLICKER_W-1:0] flicker_out,
  // AGC.
  input wire logic [SAMPLE_TIME_W-1:0] sample_time,
  input wire logic agc_busy,
  input wire logic agc_predict_start,
  input wire logic agc_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] res_reg, gl_reg;
  logic [1:0] fd_reg;
  logic [10:0] cnt_reg;
  logic [31:0] cyc_reg;
  ////////////////////////////////////////////////////////////////////////////
  // Shadow copies of the registers, taken from bus writes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res_reg <= RESIDUAL_CFG_RST;
      gl_reg <= GAIN_LIMITS_RST;
      fd_reg <= 2'h0;
      cnt_reg <= 11'h000;
    end else if (psel && penable && pwrite) begin
      case (paddr)
        ADDR_RESIDUAL_CFG: res_reg <= pwdata[7:0];
        ADDR_GAIN_LIMITS: gl_reg <= pwdata[7:0];
        ADDR_FLICKER_SHIFT: fd_reg <= pwdata[1:0];
        ADDR_AGC_COUNT_LO: cnt_reg[7:0] <= pwdata[7:0];
        ADDR_AGC_COUNT_HI: cnt_reg[10:8] <= pwdata[2:0];
        default: ;
      endcase
    end
  end
  // Counts measurement cycles after the gain reduction step.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cyc_reg <= 32'h0;
    else if (agc_predict_start) cyc_reg <= 32'h0;
    else if (agc_busy) cyc_reg <= cyc_reg + 32'h1;
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_full;
    $past(presetn) && $stable(full_start_per_sample) |-> sample_cycles_eff == (!full_start_per_sample ?
      $past(sample_cycles) : $past(sample_cycles) > 16'h9 ? $past(sample_cycles) - 16'h9 : 16'h0);
  endproperty
  a_full: assert property (p_full) else $error("Effective cycles wrong.");
  property p_floor;
    $past(presetn) && $stable(res_reg) && res_reg[3:2] <= res_reg[1:0] |-> residual_limited >= res_reg[3:2];
  endproperty
  a_floor: assert property (p_floor) else $error("Residual below floor.");
  property p_ceil;
    $past(presetn) && $stable(res_reg) |-> residual_limited <= res_reg[1:0] + 3'h1;
  endproperty
  a_ceil: assert property (p_ceil) else $error("Residual above ceiling.");
  property p_gain;
    $past(presetn) && !$past(agc_busy) && $stable(gl_reg) |-> gain_applied[0] <= gl_reg[7:4];
  endproperty
  a_gain: assert property (p_gain) else $error("Gain above maximum.");
  property p_red;
    agc_predict_start |=> gain_applied[0] == ($past(gain_applied[0]) > gl_reg[3:0] ?
      $past(gain_applied[0]) - gl_reg[3:0] : 4'h0);
  endproperty
  a_red: assert property (p_red) else $error("Gain not reduced.");
  property p_flick;
    $past(presetn) && $past(flicker_in_valid) && $stable(fd_reg) |->
      flicker_out_valid && flicker_out == $past(flicker_in) >> fd_reg;
  endproperty
  a_flick: assert property (p_flick) else $error("Flicker shift wrong.");
  property p_time;
    agc_done |-> cyc_reg == (cnt_reg + 32'h1) * (sample_time + 32'h1) * AGC_UNIT_CYCLES;
  endproperty
  a_time: assert property (p_time) else $error("AGC time wrong.");
  property p_hi;
    pready && !pwrite && paddr == ADDR_AGC_COUNT_HI |-> prdata == {29'h0, cnt_reg[10:8]};
  endproperty
  a_hi: assert property (p_hi) else $error("Count high part wrong.");
  cover property (agc_done);
  cover property (agc_predict_start && gl_reg[3:0] != 4'h0);
  cover property (flicker_out_valid && fd_reg == 2'h3);
endmodule
bind modulator_agc_config modulator_agc_config_sva #(.NCH(NCH), .FLICKER_W(FLICKER_W),
  .SAMPLE_TIME_W(SAMPLE_TIME_W)) u_sva (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .sample_cycles, .sample_cycles_eff, .full_start_per_sample, .residual_limited,
  .gain_applied, .flicker_in_valid, .flicker_in, .flicker_out_valid, .flicker_out, .sample_time,
  .agc_busy, .agc_predict_start, .agc_done);

// ---- verif/modulator_agc_config_tb.sv ----
// Self-checking bench for the modulator and AGC configuration block.
// Assumes the host model drives the register bus.
module modulator_agc_config_tb
  import modulator_agc_config_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, full_start_per_sample, err;
  logic agc_predict_req, agc_busy, agc_predict_start, agc_done, flicker_in_valid, flicker_out_valid;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, q, seed;
  logic [15:0] sample_cycles, sample_cycles_eff, sc;
  logic [2:0] residual_raw, residual_limited, rr;
  logic [1:0][3:0] gain_req, gain_applied;
  logic [7:0] sample_time, res, gl, gr, d;
  logic [23:0] flicker_in, flicker_out, fi;
  int fails, n_checks, n;
  logic [ADDR_W-1:0] adr [6] = '{ADDR_RESIDUAL_CFG, ADDR_RSVD_CFG, ADDR_GAIN_LIMITS, ADDR_FLICKER_SHIFT,
    ADDR_AGC_COUNT_LO, ADDR_AGC_COUNT_HI};
  logic [7:0] rst [6] = '{8'h03, 8'h01, 8'hc4, 8'h00, 8'h00, 8'h00};
  logic [7:0] msk [6] = '{8'h2f, 8'hff, 8'hff, 8'h03, 8'hff, 8'h07};
  modulator_agc_config u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .sample_cycles, .sample_cycles_eff, .full_start_per_sample, .residual_raw, .residual_limited,
    .gain_req, .gain_applied, .agc_predict_req, .sample_time, .agc_busy, .agc_predict_start, .agc_done,
    .flicker_in_valid, .flicker_in, .flicker_out_valid, .flicker_out);
  modulator_host_model u_host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata);
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  function automatic logic [2:0] clamp(logic [2:0] r, logic [7:0] c);
    logic [2:0] lo, hi;
    lo = c[3:2];
    hi = c[1:0] + 3'h1;
    return r < lo ? (lo > hi ? hi : lo) : (r > hi ? hi : r);
  endfunction
  function automatic logic [3:0] lim(logic [3:0] g, logic [3:0] m);
    return g > m ? m : g;
  endfunction
  function automatic logic [3:0] red(logic [3:0] g);
    return lim(g, gl[7:4]) > gl[3:0] ? lim(g, gl[7:4]) - gl[3:0] : 4'h0;
  endfunction
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("Checks %0d, mismatches %0d.", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic wr(logic [ADDR_W-1:0] a, logic [7:0] v);
    u_host.xfer(1'b1, a, {24'h0, v}, q, err);
  endtask
  task automatic rd(logic [ADDR_W-1:0] a, logic [7:0] v, string what);
    u_host.xfer(1'b0, a, 32'h0, q, err);
    chk(what, q, {24'h0, v});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    complete_run();
  end
  initial begin
    seed = 32'h13;
    {presetn, agc_predict_req, flicker_in_valid, sample_cycles, residual_raw} = '0;
    {gain_req, sample_time, flicker_in} = '0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 6; i++) rd(adr[i], rst[i], "reset value");
    rd(12'h2ac, 8'h00, "unmapped read");
    chk("unmapped error", err, 1'b1);
    for (int i = 0; i < 6; i++) begin
      d = (i == 1) ? 8'h01 : 8'(rnd()) & msk[i];
      wr(adr[i], d);
      rd(adr[i], d, "readback");
    end
    for (int k = 0; k < 24; k++) begin
      res = 8'(rnd()) & 8'h2f;
      gl = 8'(rnd());
      d = 8'(rnd()) & 8'h03;
      wr(ADDR_RESIDUAL_CFG, res);
      wr(ADDR_GAIN_LIMITS, gl);
      wr(ADDR_FLICKER_SHIFT, d);
      for (int j = 0; j < 8; j++) begin
        @(posedge pclk);
        sc = (j == 0) ? 16'(rnd() % 12) : 16'(rnd());
        rr = 3'(rnd());
        gr = 8'(rnd());
        fi = 24'(rnd());
        sample_cycles <= sc;
        residual_raw <= rr;
        gain_req <= gr;
        flicker_in <= fi;
        flicker_in_valid <= 1'b1;
        @(posedge pclk);
        #1;
        chk("full start", full_start_per_sample, res[5]);
        chk("cycles", sample_cycles_eff, !res[5] ? sc : sc > 9 ? sc - 16'h9 : 16'h0);
        chk("residual", residual_limited, clamp(rr, res));
        chk("gain", gain_applied, {lim(gr[7:4], gl[7:4]), lim(gr[3:0], gl[7:4])});
        chk("flicker", flicker_out, fi >> d[1:0]);
        chk("flicker valid", flicker_out_valid, 1'b1);
      end
    end
    for (int k = 0; k < 2; k++) begin
      gl = 8'(rnd());
      wr(ADDR_GAIN_LIMITS, gl);
      wr(ADDR_AGC_COUNT_HI, 8'h00);
      wr(ADDR_AGC_COUNT_LO, 8'(k));
      @(posedge pclk);
      gr = 8'(rnd());
      gain_req <= gr;
      sample_time <= 8'(k);
      agc_predict_req <= 1'b1;
      @(posedge pclk);
      agc_predict_req <= 1'b0;
      #1;
      chk("predict start", agc_predict_start, 1'b1);
      n = 0;
      do begin
        @(posedge pclk);
        agc_predict_req <= (n == 3);
        #1;
        n++;
        if (n == 1) chk("reduced", gain_applied, {red(gr[7:4]), red(gr[3:0])});
      end while (agc_done !== 1'b1 && n < 5000);
      chk("agc cycles", n, (k + 1) * (k + 1) * AGC_UNIT_CYCLES + 1);
      repeat (2) @(posedge pclk);
      #1;
      chk("idle", agc_busy, 1'b0);
      chk("done pulse", agc_done, 1'b0);
    end
    complete_run();
  end
endmodule

// ---- verif/modulator_host_model.sv ----
// Host model: register bus master.
// Assumes a zero or more wait state slave on pclk.
module modulator_host_model
  import modulator_agc_config_pkg::*;
(
  // Clock.
  input wire logic pclk,
  // Request.
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [ADDR_W-1:0] paddr,
  output logic [31:0] pwdata,
  // Answer.
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = 32'h0;
  end
  // One transfer; idle address and data are scrambled.
  task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] dat,
                      output logic [31:0] rdat, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= dat;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~dat;
  endtask
endmodule
